// ### logic/smc_cfg.svh
// constants for the sleep mode controller: offsets, fields, counts
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// clock rate
`define SMC_CLK_PERIOD_NS 10
// apb byte offsets
`define SMC_OFS_CTRL 8'h00
`define SMC_OFS_AUX 8'h04
`define SMC_OFS_STAT 8'h08
// sleep_mode_control_reg fields
`define SMC_SLEEP_EN_BIT 0
`define SMC_MODE_LSB 1
`define SMC_MODE_MSB 3
`define SMC_CTRL_MASK 8'h0f
// aux control fields
`define SMC_AUX_CMPD 0
`define SMC_AUX_CONV_EN 1
`define SMC_AUX_TEN 2
`define SMC_AUX_TASY 3
`define SMC_AUX_T2OVF 4
`define SMC_AUX_T2CMP 5
`define SMC_AUX_MASK 8'h3f
// mode encodings
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_NOISE 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_RSV0 3'h4
`define SMC_MODE_RSV1 3'h5
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
// timing
`define SMC_CNT_W 10
`define SMC_STBY_CYC 6
`define SMC_STALL_CYC 4
`define SMC_STARTUP_BASE_NS 1000
`define SMC_STARTUP_BASE_CYC ((`SMC_STARTUP_BASE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`endif

// ### logic/smc_pkg.sv
// types shared by the sleep mode controller
`include "smc_cfg.svh"
package smc_pkg;
  // sequencer states
  typedef enum logic [1:0] {smc_active, smc_sleep, smc_startup, smc_stall} smc_fsm_e;
  // counter word
  typedef logic [`SMC_CNT_W-1:0] smc_cnt_t;
  // clock domain and oscillator enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic converter;
    logic async_timer;
    logic usb;
    logic main_osc;
    logic timer_osc;
    logic timer_sync;
    logic pll;
  } smc_clk_en_s;
  // wake-up requests, already enabled at their source except timer2 and the comparator
  typedef struct packed {
    logic [3:0] ext_irq_lower_group;
    logic [3:0] ext_irq_upper_group;
    logic pin_change;
    logic two_wire_addr_match;
    logic two_wire_irq;
    logic timer2_ovf;
    logic timer2_cmp;
    logic nvm_ready;
    logic conv_complete;
    logic comparator_irq;
    logic wdt_irq;
    logic other_io_irq;
    logic usb_sync_irq;
    logic bus_power_transition_irq;
    logic usb_wakeup_irq;
    logic id_pin_transition_irq;
    logic host_wakeup_irq;
    logic reset_req;
  } smc_wake_s;
  localparam int SMC_WAKE_W = $bits(smc_wake_s);
  localparam int SMC_CLK_W = $bits(smc_clk_en_s);
  // module state apart from the reset release pipe
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] aux;
    logic [31:0] prdata;
    logic [SMC_WAKE_W-1:0] s1;
    logic [SMC_WAKE_W-1:0] s2;
    logic [SMC_WAKE_W-1:0] s3;
    logic [SMC_WAKE_W-1:0] filt;
    smc_fsm_e fsm;
    logic [2:0] mode;
    smc_cnt_t cnt;
    logic reset_wake;
    logic conv_start;
    logic resume;
    logic restart;
    logic [SMC_CLK_W-1:0] clk_stop;
  } smc_state_s;
endpackage

// ### logic/smc_top.sv
// sleep mode controller: apb registers, sleep sequencer, clock plan
`timescale 1ns/1ps
`include "smc_cfg.svh"

// Functional notes
// - three-bit mode field, 100/101 reserved
// - sleep only when enable bit set
// - idle stops cpu and flash clocks
// - idle wakes on external and internal irqs
// - comparator disable removes comparator wake source
// - converter enabled starts conversion entering idle/noise
// - noise mode stops io, cpu, flash clocks
// - noise mode wakes only on listed sources
// - power-down stops oscillator and all clocks
// - power-down wakes only on listed sources
// - power-down wake waits fuse start-up period
// - power-save keeps timer2, its irq wakes
// - power-save timer oscillator, sync clock timer-only
// - standby needs crystal, oscillator runs, six cycles
// - standby disables pll and usb
// - extended standby needs crystal, six cycles
// - four usb async irqs wake deep modes
// - irq wake stalls four cycles; reset restarts
module smc_top #(
  parameter int STARTUP_BASE_CYC = `SMC_STARTUP_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic sleep_instr,
  input wire logic global_irq_enable,
  input wire logic external_crystal,
  input wire logic [3:0] clock_source_fuses,
  // wake-up requests from pins and other domains
  input wire smc_pkg::smc_wake_s wake_src,
  // clock and power control
  output smc_pkg::smc_clk_en_s clk_en,
  output logic comparator_power_en,
  // sequencer status
  output logic converter_start,
  output logic core_stall,
  output logic sleeping,
  output logic irq_resume,
  output logic reset_restart
);

  ////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_q; // reset release pipe
  logic rst_n; // synchronised reset

  // async assert, two-flop release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  ////////////////////////////////////////////////////////////
  // helpers

  // clock plan for a state and mode
  function automatic smc_pkg::smc_clk_en_s clk_plan(input smc_pkg::smc_fsm_e f, input logic [2:0] m,
                                                    input logic [7:0] a);
    smc_pkg::smc_clk_en_s e;
    logic tasy;
    logic tsyn;
    tasy = a[`SMC_AUX_TEN] & a[`SMC_AUX_TASY];
    tsyn = a[`SMC_AUX_TEN] & !a[`SMC_AUX_TASY];
    e = '1;
    e.timer_osc = tasy;
    // core held off until resume
    if (f != smc_pkg::smc_active) begin
      e.cpu = 1'b0;
      e.flash = 1'b0;
    end
    if (f == smc_pkg::smc_sleep) begin
      case (m)
        // idle: only core clocks stop
        `SMC_MODE_IDLE: e.io = 1'b1;
        // noise: io clock stops too
        `SMC_MODE_NOISE: begin
          e.io = 1'b0;
          e.timer_sync = 1'b0;
        end
        // deep modes: everything off first
        default: begin
          e = '0;
          // power-save style keeps timer2 alive
          if (m[0]) begin
            e.async_timer = tasy;
            e.timer_osc = tasy;
            e.timer_sync = tsyn;
            e.main_osc = tsyn;
          end
          // standby keeps oscillator
          if (m[2]) begin
            e.main_osc = 1'b1;
          end
        end
      endcase
    end
    return e;
  endfunction

  // wake-up filter per latched mode
  function automatic logic wake_hit(input logic [2:0] m, input smc_pkg::smc_wake_s w, input logic [7:0] a,
                                    input logic gie);
    logic t2;
    logic deep;
    logic hit;
    t2 = ((w.timer2_ovf & a[`SMC_AUX_T2OVF]) | (w.timer2_cmp & a[`SMC_AUX_T2CMP])) & gie & a[`SMC_AUX_TEN];
    // asynchronous sources
    deep = w.two_wire_addr_match | (|w.ext_irq_upper_group) | (|w.ext_irq_lower_group) | w.pin_change
         | w.wdt_irq | w.bus_power_transition_irq | w.usb_wakeup_irq
         | w.id_pin_transition_irq | w.host_wakeup_irq;
    case (m)
      // idle: any enabled source
      `SMC_MODE_IDLE: hit = deep | w.two_wire_irq | t2 | w.nvm_ready | w.conv_complete | w.other_io_irq
                          | w.usb_sync_irq | (w.comparator_irq & !a[`SMC_AUX_CMPD]);
      // noise: short list only
      `SMC_MODE_NOISE: hit = w.conv_complete | w.wdt_irq | w.two_wire_irq | t2 | w.nvm_ready
                           | (|w.ext_irq_upper_group) | w.pin_change;
      // power-save and extended standby add timer2
      `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: hit = deep | t2;
      // power-down and standby
      default: hit = deep;
    endcase
    return hit;
  endfunction

  // start-up cycles minus one for a mode
  function automatic smc_pkg::smc_cnt_t startup_cnt(input logic [2:0] m, input logic [1:0] fz);
    smc_pkg::smc_cnt_t c;
    case (m)
      // oscillator never stopped
      `SMC_MODE_IDLE, `SMC_MODE_NOISE: c = '0;
      // oscillator kept: fixed short wake
      `SMC_MODE_STBY, `SMC_MODE_XSTBY: c = smc_pkg::smc_cnt_t'(`SMC_STBY_CYC - 1);
      // oscillator restart: fuse-selected period
      default: c = smc_pkg::smc_cnt_t'((STARTUP_BASE_CYC << fz) - 1);
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////
  // state

  smc_pkg::smc_state_s st; // registered state
  smc_pkg::smc_state_s next_st; // next state
  smc_pkg::smc_wake_s wk; // filtered wake requests
  logic [2:0] req_mode; // mode field in register
  logic mode_ok; // requested mode may be entered
  logic take_sleep; // sleep instruction accepted
  logic wake_now; // enabled wake source present
  logic sel_ctrl; // address decode
  logic sel_aux;
  logic sel_stat;

  assign wk = smc_pkg::smc_wake_s'(st.filt);
  assign req_mode = st.ctrl[`SMC_MODE_MSB:`SMC_MODE_LSB];
  // reserved codes, and standby without crystal, do nothing
  assign mode_ok = (req_mode != `SMC_MODE_RSV0) && (req_mode != `SMC_MODE_RSV1)
                && (!req_mode[2] || external_crystal);
  assign take_sleep = (st.fsm == smc_pkg::smc_active) && sleep_instr && st.ctrl[`SMC_SLEEP_EN_BIT] && mode_ok;
  assign wake_now = wake_hit(st.mode, wk, st.aux, global_irq_enable);
  assign sel_ctrl = paddr == `SMC_OFS_CTRL;
  assign sel_aux = paddr == `SMC_OFS_AUX;
  assign sel_stat = paddr == `SMC_OFS_STAT;

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.conv_start = 1'b0;
    next_st.resume = 1'b0;
    next_st.restart = 1'b0;
    // three-flop sync; a change counts when stages two and three agree
    next_st.s1 = wake_src;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));
    // apb setup: capture read data
    if (psel && !penable) begin
      if (sel_ctrl) begin
        next_st.prdata = 32'(st.ctrl);
      end else if (sel_aux) begin
        next_st.prdata = 32'(st.aux);
      end else if (sel_stat) begin
        next_st.prdata = 32'({st.reset_wake, st.mode, st.fsm == smc_pkg::smc_sleep});
      end else begin
        next_st.prdata = '0;
      end
    end
    // apb access: write
    if (psel && penable && pwrite) begin
      if (sel_ctrl) begin
        next_st.ctrl = pwdata[7:0] & `SMC_CTRL_MASK;
      end else if (sel_aux) begin
        next_st.aux = pwdata[7:0] & `SMC_AUX_MASK;
      end
    end
    // sleep sequencer
    case (st.fsm)
      // running: watch for sleep instruction
      smc_pkg::smc_active: begin
        if (take_sleep) begin
          next_st.mode = req_mode;
          next_st.fsm = smc_pkg::smc_sleep;
          next_st.conv_start = st.aux[`SMC_AUX_CONV_EN]
                             && (req_mode == `SMC_MODE_IDLE || req_mode == `SMC_MODE_NOISE);
        end
      end
      // asleep: reset or enabled source wakes
      smc_pkg::smc_sleep: begin
        if (wk.reset_req || wake_now) begin
          next_st.reset_wake = wk.reset_req;
          next_st.cnt = startup_cnt(st.mode, clock_source_fuses[1:0]);
          next_st.fsm = smc_pkg::smc_startup;
        end
      end
      // clock restart wait
      smc_pkg::smc_startup: begin
        if (st.cnt != '0) begin
          next_st.cnt = st.cnt - 1'b1;
        end else if (st.reset_wake) begin
          next_st.restart = 1'b1;
          next_st.fsm = smc_pkg::smc_active;
        end else begin
          next_st.cnt = smc_pkg::smc_cnt_t'(`SMC_STALL_CYC - 1);
          next_st.fsm = smc_pkg::smc_stall;
        end
      end
      // extra halt before handler
      smc_pkg::smc_stall: begin
        if (st.cnt != '0) begin
          next_st.cnt = st.cnt - 1'b1;
        end else begin
          next_st.resume = 1'b1;
          next_st.fsm = smc_pkg::smc_active;
        end
      end
      default: next_st.fsm = smc_pkg::smc_active;
    endcase
    // clock plan follows the next state
    next_st.clk_stop = ~clk_plan(next_st.fsm, next_st.mode, next_st.aux);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs

  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(sel_ctrl || sel_aux || sel_stat);
  assign clk_en = smc_pkg::smc_clk_en_s'(~st.clk_stop);
  assign comparator_power_en = !st.aux[`SMC_AUX_CMPD];
  assign converter_start = st.conv_start;
  assign core_stall = st.fsm != smc_pkg::smc_active;
  assign sleeping = st.fsm == smc_pkg::smc_sleep;
  assign irq_resume = st.resume;
  assign reset_restart = st.restart;

  ////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // four stall cycles then resume
  sequence seq_stall4;
    (st.fsm == smc_pkg::smc_stall)[*4] ##1 (irq_resume && st.fsm == smc_pkg::smc_active);
  endsequence
  // six start-up cycles then stall
  sequence seq_stby_wake;
    (st.fsm == smc_pkg::smc_startup)[*6] ##1 (st.fsm == smc_pkg::smc_stall);
  endsequence

  a_reserved_ignored: assert property ((st.fsm == smc_pkg::smc_active) && sleep_instr &&
    (req_mode == `SMC_MODE_RSV0 || req_mode == `SMC_MODE_RSV1) |=> !sleeping)
    else $error("reserved mode entered sleep");
  a_enable_needed: assert property ((st.fsm == smc_pkg::smc_active) && sleep_instr &&
    !st.ctrl[`SMC_SLEEP_EN_BIT] |=> !sleeping && !core_stall)
    else $error("sleep entered without enable");
  a_enter_latched: assert property (take_sleep |=> sleeping && st.mode == $past(req_mode))
    else $error("sleep not entered with latched mode");
  a_mode_held: assert property (sleeping && $past(sleeping) |-> $stable(st.mode))
    else $error("mode changed during sleep");
  a_idle_clocks: assert property (sleeping && st.mode == `SMC_MODE_IDLE |->
    !clk_en.cpu && !clk_en.flash && clk_en.io && clk_en.usb)
    else $error("idle clock plan wrong");
  a_noise_clocks: assert property (sleeping && st.mode == `SMC_MODE_NOISE |->
    !clk_en.io && !clk_en.cpu && clk_en.converter && clk_en.usb && clk_en.async_timer)
    else $error("noise clock plan wrong");
  a_pdown_clocks: assert property (sleeping && st.mode == `SMC_MODE_PDOWN |->
    !clk_en.main_osc && !clk_en.io && !clk_en.usb && !clk_en.converter)
    else $error("power-down clock plan wrong");
  a_standby_pll: assert property (sleeping && st.mode == `SMC_MODE_STBY |->
    !clk_en.pll && !clk_en.usb && clk_en.main_osc)
    else $error("standby pll or oscillator wrong");
  a_conv_start: assert property (take_sleep && st.aux[`SMC_AUX_CONV_EN] &&
    req_mode == `SMC_MODE_IDLE |=> converter_start)
    else $error("conversion not started");
  a_stall_four: assert property ($rose(st.fsm == smc_pkg::smc_stall) |-> seq_stall4)
    else $error("stall not four cycles");
  a_standby_six: assert property (sleeping && st.mode == `SMC_MODE_STBY && wake_now &&
    !wk.reset_req |=> seq_stby_wake)
    else $error("standby wake not six cycles");
  a_reset_wake: assert property (sleeping && wk.reset_req |=> ##[1:900] reset_restart)
    else $error("reset wake did not restart");
endmodule

// ### sim/smc_top_test.sv
// self-checking bench for the sleep mode controller
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_top_test;
  ////////////////////////////////////////////////////////////////
  // apb and core side stimulus
  logic clk, resetn, psel, penable, pwrite, sleep_instr, gie, xtal;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic pready, pslverr, err, cs, wrst;
  logic [3:0] fuses;
  // wake requests and clock plan
  smc_pkg::smc_wake_s wake;
  smc_pkg::smc_clk_en_s ce;
  // sequencer status
  logic cmp_en, conv_st, stall, slp, irq_res, rst_rs;
  int mismatches, total_checks, n, cyc, fz, m, i;
  int modes[6] = '{0, 1, 2, 3, 6, 7};
  logic [7:0] bad[5] = '{8'h04, 8'h09, 8'h0b, 8'h0d, 8'h0f};

  // short start-up base keeps deep-mode wakes quick
  smc_top #(.STARTUP_BASE_CYC(2)) DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instr(sleep_instr), .global_irq_enable(gie), .external_crystal(xtal),
    .clock_source_fuses(fuses), .wake_src(wake), .clk_en(ce), .comparator_power_en(cmp_en),
    .converter_start(conv_st), .core_stall(stall), .sleeping(slp), .irq_resume(irq_res),
    .reset_restart(rst_rs));

  // 100 MHz clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic results;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // wait, bounded, for sleeping to reach v
  task automatic wait_slp(input logic v, input int lim);
    n = 0;
    while (slp !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // program aux, set enable just before the pulse, fire the sleep instruction
  task automatic go_sleep(input logic [7:0] c, input logic [7:0] aux);
    apb(1, `SMC_OFS_AUX, {24'h0, aux});
    apb(1, `SMC_OFS_CTRL, {24'h0, c});
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    @(negedge clk);
    wait_slp(1, 3);
    cs = conv_st;
  endtask

  // raise one wake bit, hold it until the core is released, count cycles
  task automatic do_wake(input int b);
    @(posedge clk);
    wake <= smc_pkg::smc_wake_s'(24'h1 << b);
    wait_slp(0, 20);
    cyc = 0;
    while (irq_res !== 1'b1 && rst_rs !== 1'b1 && cyc < 2000) begin
      @(negedge clk);
      cyc++;
    end
    wrst = rst_rs;
    @(posedge clk);
    wake <= '0;
    apb(1, `SMC_OFS_CTRL, 32'h0);
  endtask

  // a source that must be ignored in the present mode
  task automatic no_wake(input int b);
    @(posedge clk);
    wake <= smc_pkg::smc_wake_s'(24'h1 << b);
    repeat (12) @(negedge clk);
    chk("asleep", slp, 32'h1);
    @(posedge clk);
    wake <= '0;
  endtask

  // expected {cpu, flash, io, converter, usb, main_osc} while asleep, aux timer off
  function automatic logic [5:0] exp_clk(input int md);
    return {2'b00, md == 0, md <= 1, md <= 1, md <= 1 || md >= 6};
  endfunction

  // start-up length before the four stall cycles
  function automatic int exp_up(input int md, input int f);
    return md <= 1 ? 1 : (md >= 6 ? `SMC_STBY_CYC : 2 << f);
  endfunction

  ////////////////////////////////////////////////////////////////
  // watchdog against a hung sequence
  initial begin
    #500000;
    mismatches++;
    results();
  end

  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, sleep_instr, paddr, pwdata} = '0;
    {gie, xtal, fuses, fz} = '0;
    wake = '0;
    void'($urandom(68));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cmp power", cmp_en, 32'h1);
    // reset values, status write ignored, unmapped address refused
    apb(1, `SMC_OFS_STAT, 32'hff);
    for (i = 0; i < 3; i++) begin
      apb(0, 8'(4 * i), 32'h0);
      chk("reg reset", rd, 32'h0);
    end
    apb(0, 8'h0c, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // random control words keep only enable and mode
    repeat (4) begin
      r = $urandom;
      apb(1, `SMC_OFS_CTRL, r & 32'hfffffff0);
      apb(0, `SMC_OFS_CTRL, 32'h0);
      chk("ctrl mask", rd, 32'h0);
      apb(1, `SMC_OFS_CTRL, r);
      apb(0, `SMC_OFS_CTRL, 32'h0);
      chk("ctrl rw", rd, r & 32'h0f);
    end
    // disabled, reserved, or standby without crystal: no effect
    for (i = 0; i < 5; i++) begin
      xtal <= (i < 3);
      go_sleep(bad[i], 8'h00);
      chk("no sleep", {slp, stall}, 32'h0);
      apb(1, `SMC_OFS_CTRL, 32'h0);
    end
    // every mode: clock plan, latched mode, accepted wakes; refused wakes in noise and power-down only
    foreach (modes[j]) begin
      m = modes[j];
      r = $urandom;
      fuses <= r[3:0];
      xtal <= 1'b1;
      fz = int'(r[1:0]);
      go_sleep({4'h0, 3'(m), 1'b1}, 8'h02);
      chk("asleep", {slp, stall}, 32'h3);
      chk("conv start", cs, 32'(m <= 1));
      chk("clocks", {ce.cpu, ce.flash, ce.io, ce.converter, ce.usb, ce.main_osc}, exp_clk(m));
      if (m == 6) chk("pll", ce.pll, 32'h0);
      apb(1, `SMC_OFS_CTRL, {28'h0, ~3'(m), 1'b1});
      apb(0, `SMC_OFS_STAT, 32'h0);
      chk("stat mode", rd & 32'h0f, {28'h0, 3'(m), 1'b1});
      if (m == 2) begin
        foreach (bad[k]) no_wake(k == 1 ? 6 : 5 + (k * 2));
      end
      if (m == 1) begin
        no_wake(20);
        no_wake(6);
      end
      do_wake(16 + ($urandom % 4));
      chk("irq wake len", cyc, exp_up(m, fz) + `SMC_STALL_CYC);
      chk("released", {stall, wrst}, 32'h0);
    end
    // four usb asynchronous sources leave power-down
    for (i = 1; i <= 4; i++) begin
      go_sleep(8'h05, 8'h00);
      do_wake(i);
      chk("usb wake", cyc, exp_up(2, fz) + `SMC_STALL_CYC);
    end
    // reset during standby restarts without stall
    go_sleep(8'h0d, 8'h00);
    do_wake(0);
    chk("reset wake", {wrst, 28'h0, 3'(cyc)}, {1'b1, 28'h0, 3'(`SMC_STBY_CYC)});
    apb(0, `SMC_OFS_STAT, 32'h0);
    chk("stat reset", rd[4], 32'h1);
    // power-save timer wake needs the global enable
    @(posedge clk);
    gie <= 1'b0;
    go_sleep(8'h07, 8'h2c);
    chk("timer clocks", {ce.async_timer, ce.timer_osc, ce.timer_sync, ce.main_osc}, 32'hc);
    no_wake(11);
    // let the stale compare request drain before the global enable rises
    repeat (5) @(posedge clk);
    gie <= 1'b1;
    no_wake(12);
    do_wake(11);
    chk("timer wake", cyc, exp_up(3, fz) + `SMC_STALL_CYC);
    // comparator disabled cannot wake idle
    go_sleep(8'h01, 8'h01);
    chk("cmp power", cmp_en, 32'h0);
    no_wake(8);
    do_wake(21);
    chk("idle wake", cyc, 32'd5);
    results();
  end
endmodule
